//--- hdl/strap_defaults_pkg.sv
// constants for the port 1 / phy a strap default loader
// Summary of operation
// - speed strap (default 1) sets rate-select-low reset value and steers phy mode field
// - speed strap sets reset values of both 10BASE-T advertised capability bits
// - duplex strap (default 1) sets duplex bit reset value and steers phy mode field on copper
// - duplex strap sets only the 10BASE-T full-duplex advertised bit
// - in fibre mode speed and pause straps leave phy defaults alone
// - backpressure strap (default 1) sets port 1 backpressure enable reset value
// - full-duplex pause strap (default 1) sets transmit and receive pause enables
// - full-duplex pause strap also sets advertised asymmetric pause bit
// - forced pause strap (default 0) sets port 1 forced pause select bit
// - forced pause strap also sets advertised asymmetric and symmetric pause bits
// - low power idle strap pin sets mac low power idle enable reset value
// - in fibre mode the low power idle strap has no effect
// - low power idle strap also sets phy enable, capability and advertisement bits
package strap_defaults_pkg;
	// documented default strap levels
	localparam logic SPEED_DEFAULT      = 1'h1;
	localparam logic DUPLEX_DEFAULT     = 1'h1;
	localparam logic BACKPRESSURE_DEFAULT = 1'h1;
	localparam logic FD_PAUSE_DEFAULT   = 1'h1;
	localparam logic FORCED_PAUSE_DEFAULT = 1'h0;
	// phy mode field
	localparam int   MODE_W             = 3;
	localparam logic [2:0] MODE_10HD    = 3'h0;
	localparam logic [2:0] MODE_10FD    = 3'h1;
	localparam logic [2:0] MODE_100HD   = 3'h2;
	localparam logic [2:0] MODE_100FD   = 3'h3;
	localparam logic [2:0] MODE_ALL     = 3'h7;
	// loader sequence
	typedef enum logic [1:0] {
		ST_RESET = 2'h0,
		ST_SYNC  = 2'h1,
		ST_LOAD  = 2'h2,
		ST_RUN   = 2'h3
	} load_state_type;
	// sync stages before the strap sample is trusted
	localparam logic [1:0] SYNC_CYCLES  = 2'h2;
endpackage

//--- hdl/port1_phya_strap_defaults.sv
// port 1 and phy a strap default loader with software-writable fields
`timescale 1ns/1ps
`default_nettype none
module port1_phya_strap_defaults (
	// clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_rst_b,
	// strap pins, sampled once after reset
	input  wire logic       i_speed_strap,
	input  wire logic       i_duplex_strap,
	input  wire logic       i_port1_backpressure_default_cfg,
	input  wire logic       i_port1_fullduplex_pause_default_cfg,
	input  wire logic       i_port1_forced_pause_default_cfg,
	input  wire logic       i_low_power_idle_strap_pin,
	input  wire logic       i_fibre_mode,
	// software field writes
	input  wire logic       i_sw_wr,
	input  wire logic [15:0] i_sw_data,
	// loaded field values
	output logic            o_load_done,
	output logic            o_phy_rate_select_low,
	output logic            o_phy_full_duplex_sel,
	output logic [2:0]      o_phy_mode,
	output logic            o_adv_10fd,
	output logic            o_adv_10hd,
	output logic            o_adv_asym_pause,
	output logic            o_adv_sym_pause,
	output logic            o_port1_backpressure_on,
	output logic            o_port1_tx_pause_on,
	output logic            o_port1_rx_pause_on,
	output logic            o_port1_forced_pause_sel,
	output logic            o_mac_low_power_idle_on,
	output logic            o_phy_low_power_idle_on,
	output logic            o_phy_eee_cap_100,
	output logic            o_phy_eee_adv_100
);
	typedef struct packed {
		strap_defaults_pkg::load_state_type st;
		logic        done;  // straps applied, software now owns the fields
		logic [1:0]  cnt;
		logic [6:0]  s1;    // first sync stage, read only by s2
		logic [6:0]  s2;
		logic [15:0] f;     // field image
	} state_type;

	state_type st_reg;
	state_type st_next;

	// field image bit positions, the same layout as a software write
	localparam int F_RATE  = 0;
	localparam int F_DUP   = 1;
	localparam int F_MODE  = 2;
	localparam int F_A10FD = 5;
	localparam int F_A10HD = 6;
	localparam int F_ASYM  = 7;
	localparam int F_SYM   = 8;
	localparam int F_BP    = 9;
	localparam int F_TXP   = 10;
	localparam int F_RXP   = 11;
	localparam int F_FRC   = 12;
	localparam int F_MLPI  = 13;
	localparam int F_PLPI  = 14;
	localparam int F_CAP   = 15;

	// strap vector order, as packed into the sync stages
	localparam int S_SPEED  = 0;
	localparam int S_DUPLEX = 1;
	localparam int S_BP     = 2;
	localparam int S_FDP    = 3;
	localparam int S_FRC    = 4;
	localparam int S_LPI    = 5;
	localparam int S_FIBRE  = 6;

	// field image while reset is asserted: strap default levels, advertisement and low power bits low
	localparam logic [15:0] RESET_IMAGE = {3'h0, strap_defaults_pkg::FORCED_PAUSE_DEFAULT,
		strap_defaults_pkg::FD_PAUSE_DEFAULT, strap_defaults_pkg::FD_PAUSE_DEFAULT,
		strap_defaults_pkg::BACKPRESSURE_DEFAULT, 4'h0, strap_defaults_pkg::MODE_100FD,
		strap_defaults_pkg::DUPLEX_DEFAULT, strap_defaults_pkg::SPEED_DEFAULT};

	// mode field from rate and duplex straps
	function automatic logic [2:0] mode_of(input logic rate, input logic dup);
		case ({rate, dup})
			2'h0:    mode_of = strap_defaults_pkg::MODE_10HD;
			2'h1:    mode_of = strap_defaults_pkg::MODE_10FD;
			2'h2:    mode_of = strap_defaults_pkg::MODE_100HD;
			default: mode_of = strap_defaults_pkg::MODE_100FD;
		endcase
	endfunction

	// switch side fields follow their straps whatever the phy does, except mac low power idle, which fibre forces off
	function automatic logic [15:0] switch_image(input logic [15:0] img_in, input logic [6:0] smp);
		logic [15:0] img;
		img          = img_in;
		img[F_BP]    = smp[S_BP];
		img[F_TXP]   = smp[S_FDP];
		img[F_RXP]   = smp[S_FDP];
		img[F_FRC]   = smp[S_FRC];
		// no autonegotiation on fibre, so no low power idle either
		img[F_MLPI]  = smp[S_LPI] & ~smp[S_FIBRE];
		switch_image = img;
	endfunction

	// phy fields on fibre: fixed values, only the duplex strap still counts
	function automatic logic [15:0] fibre_image(input logic [15:0] img_in, input logic [6:0] smp);
		logic [15:0] img;
		img              = img_in;
		img[F_RATE]      = 1'h1;
		img[F_DUP]       = smp[S_DUPLEX];
		img[F_MODE +: 3] = strap_defaults_pkg::MODE_ALL;
		img[F_A10FD]     = smp[S_DUPLEX];
		img[F_A10HD]     = 1'h1;
		// pause and low power advertisement stay off without negotiation
		img[F_ASYM]      = 1'h0;
		img[F_SYM]       = 1'h0;
		img[F_PLPI]      = 1'h0;
		img[F_CAP]       = 1'h0;
		fibre_image      = img;
	endfunction

	// phy fields on copper: every phy-side strap applies
	function automatic logic [15:0] copper_image(input logic [15:0] img_in, input logic [6:0] smp);
		logic [15:0] img;
		img              = img_in;
		img[F_RATE]      = smp[S_SPEED];
		img[F_DUP]       = smp[S_DUPLEX];
		img[F_MODE +: 3] = mode_of(smp[S_SPEED], smp[S_DUPLEX]);
		// 10 Mb/s full duplex needs both the rate and the duplex strap
		img[F_A10FD]     = smp[S_SPEED] & smp[S_DUPLEX];
		img[F_A10HD]     = smp[S_SPEED];
		// forced pause advertises both pause kinds, full-duplex pause only the asymmetric one
		img[F_ASYM]      = smp[S_FDP] | smp[S_FRC];
		img[F_SYM]       = smp[S_FRC];
		// one bit serves both the capability and the advertisement output
		img[F_PLPI]      = smp[S_LPI];
		img[F_CAP]       = smp[S_LPI];
		copper_image     = img;
	endfunction

	// the whole load: switch side first, then the phy side chosen by the fibre strap
	function automatic logic [15:0] load_image(input logic [6:0] smp);
		logic [15:0] img;
		img = switch_image(16'h0000, smp);
		if (smp[S_FIBRE]) begin
			img = fibre_image(img, smp);
		end else begin
			img = copper_image(img, smp);
		end
		load_image = img;
	endfunction

	// sequencer: sync straps, let the sample settle, load once, then follow software
	// hazard: straps must stand still from reset release until the load, there is no
	// second sample and no glitch filter beyond the two sync stages
	always_comb begin
		st_next    = st_reg;
		// two flip-flops between the strap pins and any logic
		st_next.s1 = {i_fibre_mode, i_low_power_idle_strap_pin, i_port1_forced_pause_default_cfg,
			i_port1_fullduplex_pause_default_cfg, i_port1_backpressure_default_cfg,
			i_duplex_strap, i_speed_strap};
		st_next.s2 = st_reg.s1;
		case (st_reg.st)
			strap_defaults_pkg::ST_RESET: begin
				// first edge after release: start the settle count
				st_next.st  = strap_defaults_pkg::ST_SYNC;
				st_next.cnt = 2'h0;
			end
			strap_defaults_pkg::ST_SYNC: begin
				// s2 only holds a clean sample once both stages have refilled
				st_next.cnt = st_reg.cnt + 2'h1;
				if (st_reg.cnt == strap_defaults_pkg::SYNC_CYCLES) begin
					st_next.st = strap_defaults_pkg::ST_LOAD;
				end
			end
			strap_defaults_pkg::ST_LOAD: begin
				// the only place the straps ever reach the fields
				st_next.f    = load_image(st_reg.s2);
				st_next.done = 1'h1;
				st_next.st   = strap_defaults_pkg::ST_RUN;
			end
			default: begin
				// writes before the load are dropped; after it they stick until reset
				if (i_sw_wr) begin
					st_next.f = i_sw_data;
				end
			end
		endcase
	end

	// state register; reset holds the default levels until the load replaces them
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_reg <= '{st: strap_defaults_pkg::ST_RESET, done: 1'h0, cnt: 2'h0, s1: 7'h00, s2: 7'h00,
				f: RESET_IMAGE};
		end else begin
			st_reg <= st_next;
		end
	end

	// load flag straight from its own flip-flop
	assign o_load_done             = st_reg.done;

	// phy control and advertisement fields straight from the register
	assign o_phy_rate_select_low   = st_reg.f[F_RATE];
	assign o_phy_full_duplex_sel   = st_reg.f[F_DUP];
	assign o_phy_mode              = st_reg.f[F_MODE +: 3];
	assign o_adv_10fd              = st_reg.f[F_A10FD];
	assign o_adv_10hd              = st_reg.f[F_A10HD];
	assign o_adv_asym_pause        = st_reg.f[F_ASYM];
	assign o_adv_sym_pause         = st_reg.f[F_SYM];

	// switch port fields straight from the register
	assign o_port1_backpressure_on = st_reg.f[F_BP];
	assign o_port1_tx_pause_on     = st_reg.f[F_TXP];
	assign o_port1_rx_pause_on     = st_reg.f[F_RXP];
	assign o_port1_forced_pause_sel = st_reg.f[F_FRC];

	// low power idle fields; capability and advertisement share one bit
	assign o_mac_low_power_idle_on = st_reg.f[F_MLPI];
	assign o_phy_low_power_idle_on = st_reg.f[F_PLPI];
	assign o_phy_eee_cap_100       = st_reg.f[F_CAP];
	assign o_phy_eee_adv_100       = st_reg.f[F_CAP];
endmodule
`default_nettype wire

//--- verification/strap_board.sv
// board strap levels seen by the loader at reset
`timescale 1ns/1ps
`default_nettype none
module strap_board (input wire logic i_dflt, input wire logic [6:0] i_set, output logic [6:0] o_strap);
	assign o_strap = i_dflt ? {i_set[6:5], 5'h0f} : i_set; // unfitted straps rest at their default levels
endmodule
`default_nettype wire

//--- verification/strap_asserts.sv
// assertions on the strap default loader ports
`timescale 1ns/1ps
`default_nettype none
module strap_asserts (
	input wire logic        i_mclk, i_rst_b, i_speed_strap, i_duplex_strap, i_fibre_mode, i_sw_wr, o_load_done,
	input wire logic        o_phy_rate_select_low, o_phy_full_duplex_sel, o_adv_10fd, o_adv_10hd,
	input wire logic [15:0] i_sw_data,
	input wire logic [2:0]  o_phy_mode
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	// the load edge, and the load on copper
	sequence s_ld; $rose(o_load_done); endsequence
	sequence s_cu; s_ld ##0 !i_fibre_mode; endsequence
	property p_rate; s_cu |-> o_phy_rate_select_low == i_speed_strap; endproperty
	a_rate: assert property (p_rate) else $error("rate");
	property p_mode; s_cu |-> o_phy_mode == {1'h0, i_speed_strap, i_duplex_strap}; endproperty
	a_mode: assert property (p_mode) else $error("mode");
	property p_dup; s_ld |-> o_phy_full_duplex_sel == i_duplex_strap; endproperty
	a_dup: assert property (p_dup) else $error("duplex");
	property p_fd; s_cu |-> o_adv_10fd == (i_speed_strap & i_duplex_strap); endproperty
	a_fd: assert property (p_fd) else $error("10fd");
	property p_hd; s_cu |-> o_adv_10hd == i_speed_strap; endproperty
	a_hd: assert property (p_hd) else $error("10hd");
	property p_fx; s_ld ##0 i_fibre_mode |-> o_phy_mode == 3'h7 && o_adv_10hd; endproperty
	a_fx: assert property (p_fx) else $error("fibre");
	property p_wr; logic [2:0] m; (o_load_done && i_sw_wr, m = i_sw_data[4:2]) |=> o_phy_mode == m; endproperty
	a_wr: assert property (p_wr) else $error("write");
	property p_once; o_load_done |=> o_load_done [*3]; endproperty
	a_once: assert property (p_once) else $error("reload");
endmodule
bind port1_phya_strap_defaults strap_asserts chk (.*);
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the strap default loader
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk = 1'h0, rst_b = 1'h0, dflt = 1'h0, wr = 1'h0;
	logic [6:0]  set = 7'h00;
	logic [15:0] wd = 16'h0000;
	wire  [6:0]  s;
	wire  [17:0] img;
	int          err_count = 0, checks = 0;
	initial forever #50 clk = ~clk;
	strap_board brd (.i_dflt(dflt), .i_set(set), .o_strap(s));
	port1_phya_strap_defaults dut (.i_mclk(clk), .i_rst_b(rst_b), .i_speed_strap(s[0]), .i_duplex_strap(s[1]),
		.i_port1_backpressure_default_cfg(s[2]), .i_port1_fullduplex_pause_default_cfg(s[3]), .i_fibre_mode(s[6]),
		.i_port1_forced_pause_default_cfg(s[4]), .i_low_power_idle_strap_pin(s[5]), .i_sw_wr(wr), .i_sw_data(wd),
		.o_phy_rate_select_low(img[0]), .o_phy_full_duplex_sel(img[1]), .o_phy_mode(img[4:2]), .o_adv_10fd(img[5]),
		.o_adv_10hd(img[6]), .o_adv_asym_pause(img[7]), .o_adv_sym_pause(img[8]), .o_port1_backpressure_on(img[9]),
		.o_port1_tx_pause_on(img[10]), .o_port1_rx_pause_on(img[11]), .o_port1_forced_pause_sel(img[12]),
		.o_mac_low_power_idle_on(img[13]), .o_phy_low_power_idle_on(img[14]), .o_phy_eee_adv_100(img[15]),
		.o_phy_eee_cap_100(img[16]), .o_load_done(img[17]));
	// field image expected from a strap set, load flag on top
	function automatic logic [17:0] ex(input logic [6:0] v);
		return v[6] ? {5'h10, v[4], v[3], v[3], v[2], 2'h0, 1'h1, v[1], 3'h7, v[1], 1'h1} : {1'h1, {4{v[5]}},
			v[4], v[3], v[3], v[2], v[4], v[3] | v[4], v[0], v[0] & v[1], 1'h0, v[0], v[1], v[1], v[0]};
	endfunction
	task automatic chk(input logic [17:0] e);
		checks++;
		err_count += int'(img !== e);
		if (img !== e) $display("FAIL %0t got %h want %h", $time, img, e);
	endtask
	task automatic test_done;
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// reset with straps set, write too early, wait for the load, compare
	task automatic boot(input logic [6:0] v, input logic d, input logic [17:0] e);
		@(negedge clk) {rst_b, dflt, set} = {1'h0, d, v};
		repeat (20) @(negedge clk);
		{rst_b, wr} = 2'h3;
		@(negedge clk) wr = 1'h0;
		for (int i = 0; i < 20 && img[17] !== 1'h1; i++) @(negedge clk);
		chk(e);
		if (img[17] !== 1'h1) test_done;
	endtask
	// back-to-back writes land and stand after a fibre load
	task automatic t_writes;
		boot(7'h5f, 1'h0, ex(7'h5f));
		{wr, wd} = {1'h1, 16'ha5c3};
		@(negedge clk) chk({2'h3, 16'ha5c3});
		wd = 16'h5a3c;
		@(negedge clk) wr = 1'h0;
		@(negedge clk) chk({2'h2, 16'h5a3c});
	endtask
	// board defaults, then every strap combination
	task automatic t_straps;
		boot(7'h00, 1'h1, 18'h20eef);
		for (int v = 0; v < 128; v++)
			boot(v[6:0], 1'h0, ex(v[6:0]));
	endtask
	initial begin
		t_writes;
		t_straps;
		test_done;
	end
endmodule
`default_nettype wire
